/* File: logic/nfcic_top.sv */
// nfc controller reset/init interpreter and clock request logic
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - reset notice carries hardware and rom version bytes
// - bytes two, three hold firmware major, minor
// - reset-configuration reset discards whole nci configuration
// - proprietary notifications only after extension activation
// - activation answer: same codes, two parameters
// - activation status only ok or failed
// - status followed by four-byte build id
// - crystal or pll input clock source
// - clock request raised when pll clock needed
// - clock deemed stable after programmed timeout
// - reset answer held until pending output read
module nfcic_top #(
	parameter logic [7:0]  HW_VER   = 8'h11, // arbitrary value
	parameter logic [7:0]  ROM_VER  = 8'h22, // arbitrary value
	parameter logic [7:0]  FW_MAJOR = 8'h01, // arbitrary value
	parameter logic [7:0]  FW_MINOR = 8'h00, // arbitrary value
	parameter logic [31:0] BUILD_ID = 32'h0000_0001 // arbitrary value
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address, data and response
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	// axi4-lite read
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	// proprietary event source
	input  wire logic        prop_event,
	// host-facing pins and status
	output logic             data_pending,
	output logic             clock_request_pin,
	output logic             clock_stable,
	output logic             carrier_on
);
	// bus slave state
	logic        aw_got_r, w_got_r;
	logic [7:0]  wa_r;
	logic [31:0] wd_r;
	logic [3:0]  ws_r;
	logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [1:0]  bresp_r, rresp_r;
	logic [31:0] rdata_r;
	// block state
	nfcic_pkg::nfcic_seq_t seq_r;
	logic        rst_wait_r, rst_keep_r;
	logic        ext_en_r;       // activation accepted
	logic        rsp_v_r, ntf_v_r, pntf_r;
	logic [3:0]  rsp_gid_r;
	logic [5:0]  rsp_oid_r;
	logic [7:0]  rsp_plen_r, rsp_stat_r;
	logic        mapped_r, routed_r, disc_r;
	logic [31:0] clkcfg_r, ctrl_r, ncicfg_r;
	logic        clk_req_r, clk_ok_r, irq_r;
	logic [15:0] tick_cnt_r;
	logic [5:0]  pre_r;
	// decoded strobes
	logic        wr_go, rd_go, cmd_wr, rst_exec, pend, need;
	logic [3:0]  c_gid;
	logic [5:0]  c_oid;
	logic [7:0]  c_plen;
	logic        is_reset, run_cmd;
	logic [31:0] rd_val;
	logic        rd_hit, wr_hit;
	logic [7:0]  new_stat;
	logic [31:0] mfr_word;

	// a write completes once both halves are held and no answer waits
	assign wr_go  = aw_got_r & w_got_r & ~bvalid_r;
	assign rd_go  = s_arvalid & arready_r;
	assign c_gid  = wd_r[nfcic_pkg::HDR_GID +: 4];
	assign c_oid  = wd_r[nfcic_pkg::HDR_OID +: 6];
	assign c_plen = wd_r[nfcic_pkg::HDR_PLEN +: 8];
	assign cmd_wr = wr_go & (wa_r == nfcic_pkg::OFS_CMD);
	assign is_reset = (c_gid == nfcic_pkg::GID_CORE) & (c_oid == nfcic_pkg::OID_RESET);
	// commands written during a held reset are dropped
	assign run_cmd  = cmd_wr & ~is_reset & ~rst_wait_r;
	assign pend     = rsp_v_r | ntf_v_r | pntf_r;
	assign rst_exec = rst_wait_r & ~pend;
	assign mfr_word = {FW_MINOR, FW_MAJOR, ROM_VER, HW_VER};
	// clock needed only for carrier or firmware download in pll mode
	assign need = clkcfg_r[nfcic_pkg::CLK_PLL] & (disc_r | ctrl_r[nfcic_pkg::CTRL_FWDL]);

	// write address / data capture, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			wa_r      <= 8'h00;
			wd_r      <= 32'h0000_0000;
			ws_r      <= 4'h0;
		end else begin
			awready_r <= ~aw_got_r & ~(s_awvalid & awready_r) & ~wr_go;
			wready_r  <= ~w_got_r & ~(s_wvalid & wready_r) & ~wr_go;
			if (s_awvalid && awready_r) begin
				aw_got_r <= 1'b1;
				wa_r     <= {s_awaddr[7:2], 2'b00};
			end else if (wr_go) begin
				aw_got_r <= 1'b0;
			end
			if (s_wvalid && wready_r) begin
				w_got_r <= 1'b1;
				wd_r    <= s_wdata;
				ws_r    <= s_wstrb;
			end else if (wr_go) begin
				w_got_r <= 1'b0;
			end
		end
	end

	// write answer, slverr for unmapped or read-only words
	always_comb begin
		case (wa_r)
			nfcic_pkg::OFS_CMD, nfcic_pkg::OFS_CLKCFG,
			nfcic_pkg::OFS_CTRL, nfcic_pkg::OFS_NCICFG: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= nfcic_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_hit ? nfcic_pkg::RESP_OKAY : nfcic_pkg::RESP_SLVERR;
		end else if (s_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// software-writable words, byte lanes honoured
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clkcfg_r <= nfcic_pkg::CLKCFG_RST; // crystal mode
			ctrl_r   <= 32'h0000_0000;
			ncicfg_r <= 32'h0000_0000;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (wr_go && ws_r[i]) begin
					if (wa_r == nfcic_pkg::OFS_CLKCFG)
						clkcfg_r[8*i +: 8] <= wd_r[8*i +: 8];
					if (wa_r == nfcic_pkg::OFS_CTRL)
						ctrl_r[8*i +: 8] <= wd_r[8*i +: 8];
				end
			end
			// reset-configuration wipes nci parameters; clock words survive
			if (rst_exec && !rst_keep_r) begin
				ncicfg_r <= 32'h0000_0000;
			end else begin
				for (int i = 0; i < 4; i++) begin
					if (wr_go && ws_r[i] && wa_r == nfcic_pkg::OFS_NCICFG)
						ncicfg_r[8*i +: 8] <= wd_r[8*i +: 8];
				end
			end
		end
	end

	// reset command is held while output data is still unread
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst_wait_r <= 1'b0;
			rst_keep_r <= 1'b0;
		end else if (cmd_wr && is_reset && !rst_wait_r) begin
			rst_wait_r <= 1'b1;
			rst_keep_r <= wd_r[nfcic_pkg::CMD_KEEP];
		end else if (rst_exec) begin
			rst_wait_r <= 1'b0;
		end
	end

	// reset then init, with nothing between
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seq_r <= nfcic_pkg::SQ_IDLE;
		end else if (rst_exec) begin
			seq_r <= nfcic_pkg::SQ_RST;
		end else if (run_cmd) begin
			case (seq_r)
				nfcic_pkg::SQ_RST: begin
					// any other command breaks the pair
					if (c_gid == nfcic_pkg::GID_CORE && c_oid == nfcic_pkg::OID_INIT)
						seq_r <= nfcic_pkg::SQ_READY;
					else
						seq_r <= nfcic_pkg::SQ_IDLE;
				end
				nfcic_pkg::SQ_READY: seq_r <= nfcic_pkg::SQ_READY;
				default: seq_r <= nfcic_pkg::SQ_IDLE;
			endcase
		end
	end

	// status of a non-reset command
	always_comb begin
		new_stat = nfcic_pkg::STAT_FAILED;
		case (c_gid)
			nfcic_pkg::GID_CORE: begin
				if (c_oid == nfcic_pkg::OID_INIT && seq_r == nfcic_pkg::SQ_RST)
					new_stat = nfcic_pkg::STAT_OK;
				if (c_oid == nfcic_pkg::OID_SETCFG && seq_r == nfcic_pkg::SQ_READY)
					new_stat = nfcic_pkg::STAT_OK;
			end
			nfcic_pkg::GID_RF: begin
				// modes start only after a completed reset/init pair
				if (seq_r == nfcic_pkg::SQ_READY)
					new_stat = nfcic_pkg::STAT_OK;
			end
			nfcic_pkg::GID_EXT: begin
				// only ok or failed may come back
				if (c_oid == nfcic_pkg::OID_EXT_ACT && c_plen == 8'h00 &&
				    seq_r == nfcic_pkg::SQ_READY)
					new_stat = nfcic_pkg::STAT_OK;
			end
			default: new_stat = nfcic_pkg::STAT_FAILED;
		endcase
	end

	// response word; a new answer wins over a read that clears it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rsp_v_r    <= 1'b0;
			rsp_gid_r  <= 4'h0;
			rsp_oid_r  <= 6'h00;
			rsp_plen_r <= 8'h00;
			rsp_stat_r <= 8'h00;
		end else if (rst_exec) begin
			rsp_v_r    <= 1'b1;
			rsp_gid_r  <= nfcic_pkg::GID_CORE;
			rsp_oid_r  <= nfcic_pkg::OID_RESET;
			rsp_plen_r <= nfcic_pkg::PLEN_STAT;
			rsp_stat_r <= nfcic_pkg::STAT_OK;
		end else if (run_cmd) begin
			rsp_v_r    <= 1'b1;
			rsp_gid_r  <= c_gid;
			rsp_oid_r  <= c_oid;
			rsp_stat_r <= new_stat;
			// activation answer: status byte plus build id
			rsp_plen_r <= (c_gid == nfcic_pkg::GID_EXT) ?
				nfcic_pkg::PLEN_EXT : nfcic_pkg::PLEN_STAT;
		end else if (rd_go && s_araddr[7:2] == nfcic_pkg::OFS_RSP[7:2]) begin
			rsp_v_r <= 1'b0;
		end
	end

	// notifications and extension enable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_en_r <= 1'b0;
			ntf_v_r  <= 1'b0;
			pntf_r   <= 1'b0;
		end else begin
			// reboot forgets the activation
			if (rst_exec)
				ext_en_r <= 1'b0;
			else if (run_cmd && c_gid == nfcic_pkg::GID_EXT && new_stat == nfcic_pkg::STAT_OK)
				ext_en_r <= 1'b1;
			if (rst_exec)
				ntf_v_r <= 1'b1;
			else if (rd_go && s_araddr[7:2] == nfcic_pkg::OFS_MFR[7:2])
				ntf_v_r <= 1'b0;
			// events without activation are simply not reported
			if (prop_event && ext_en_r)
				pntf_r <= 1'b1;
			else if (rd_go && s_araddr[7:2] == nfcic_pkg::OFS_STATUS[7:2])
				pntf_r <= 1'b0;
		end
	end

	// mode configuration held by the device
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mapped_r <= 1'b0;
			routed_r <= 1'b0;
			disc_r   <= 1'b0;
		end else if (rst_exec) begin
			// discovery always stops; tables lost only without keep
			disc_r <= 1'b0;
			if (!rst_keep_r) begin
				mapped_r <= 1'b0;
				routed_r <= 1'b0;
			end
		end else if (run_cmd && c_gid == nfcic_pkg::GID_RF && new_stat == nfcic_pkg::STAT_OK) begin
			if (c_oid == nfcic_pkg::OID_MAP)
				mapped_r <= 1'b1;
			if (c_oid == nfcic_pkg::OID_ROUTING)
				routed_r <= 1'b1;
			if (c_oid == nfcic_pkg::OID_DISCOVER)
				disc_r <= 1'b1;
		end
	end

	// clock request and settle timer; no edge of the pll clock is used
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_req_r  <= 1'b0;
			clk_ok_r   <= 1'b0;
			tick_cnt_r <= 16'h0000;
			pre_r      <= 6'h00;
		end else begin
			clk_req_r <= need;
			if (!clk_req_r || !need) begin
				clk_ok_r   <= 1'b0;
				tick_cnt_r <= 16'h0000;
				pre_r      <= 6'h00;
			end else if (!clk_ok_r) begin
				// whole microsecond ticks against the programmed timeout
				if (tick_cnt_r == clkcfg_r[nfcic_pkg::CLK_TMO +: 16]) begin
					clk_ok_r <= 1'b1;
				end else if (pre_r == 6'(nfcic_pkg::TICK_CYC - 1)) begin
					pre_r      <= 6'h00;
					tick_cnt_r <= tick_cnt_r + 16'h0001;
				end else begin
					pre_r <= pre_r + 6'h01;
				end
			end
		end
	end

	// pending flag for the host
	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq_r <= 1'b0;
		else
			irq_r <= pend;
	end

	// read mux
	always_comb begin
		rd_hit = 1'b1;
		rd_val = 32'h0000_0000;
		case ({s_araddr[7:2], 2'b00})
			nfcic_pkg::OFS_CMD: rd_val = 32'h0000_0000;
			nfcic_pkg::OFS_RSP: begin
				rd_val[nfcic_pkg::HDR_GID +: 4]  = rsp_gid_r;
				rd_val[nfcic_pkg::HDR_OID +: 6]  = rsp_oid_r;
				rd_val[nfcic_pkg::HDR_PLEN +: 8] = rsp_plen_r;
				rd_val[nfcic_pkg::RSP_VLD]       = rsp_v_r;
			end
			nfcic_pkg::OFS_RSPSTAT: rd_val = {24'h00_0000, rsp_stat_r};
			nfcic_pkg::OFS_BUILD:   rd_val = BUILD_ID;
			nfcic_pkg::OFS_MFR:     rd_val = mfr_word;
			nfcic_pkg::OFS_STATUS: begin
				rd_val[nfcic_pkg::ST_READY] = (seq_r == nfcic_pkg::SQ_READY);
				rd_val[nfcic_pkg::ST_EXT]   = ext_en_r;
				rd_val[nfcic_pkg::ST_CLKRQ] = clk_req_r;
				rd_val[nfcic_pkg::ST_CLKOK] = clk_ok_r;
				rd_val[nfcic_pkg::ST_RWAIT] = rst_wait_r;
				rd_val[nfcic_pkg::ST_PNTF]  = pntf_r;
				rd_val[nfcic_pkg::ST_DISC]  = disc_r;
				rd_val[nfcic_pkg::ST_RSPV]  = rsp_v_r;
				rd_val[nfcic_pkg::ST_NTFV]  = ntf_v_r;
			end
			nfcic_pkg::OFS_CLKCFG: rd_val = clkcfg_r;
			nfcic_pkg::OFS_CTRL:   rd_val = ctrl_r;
			nfcic_pkg::OFS_NCICFG: rd_val = ncicfg_r;
			default: rd_hit = 1'b0;
		endcase
	end

	// read channel, one read under way at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= nfcic_pkg::RESP_OKAY;
		end else if (rd_go) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rdata_r   <= rd_val;
			rresp_r   <= rd_hit ? nfcic_pkg::RESP_OKAY : nfcic_pkg::RESP_SLVERR;
		end else if (rvalid_r && s_rready) begin
			rvalid_r <= 1'b0;
		end else if (!rvalid_r) begin
			arready_r <= 1'b1;
		end
	end

	assign s_awready         = awready_r;
	assign s_wready          = wready_r;
	assign s_bvalid          = bvalid_r;
	assign s_bresp           = bresp_r;
	assign s_arready         = arready_r;
	assign s_rvalid          = rvalid_r;
	assign s_rdata           = rdata_r;
	assign s_rresp           = rresp_r;
	assign data_pending      = irq_r;
	assign clock_request_pin = clk_req_r;
	assign clock_stable      = clk_ok_r;
	assign carrier_on        = disc_r;

	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_ext_status: assert property (run_cmd && c_gid == nfcic_pkg::GID_EXT |=>
		rsp_stat_r == nfcic_pkg::STAT_OK || rsp_stat_r == nfcic_pkg::STAT_FAILED)
		else $error("activation status out of range");
	a_ext_shape: assert property (run_cmd && c_gid == nfcic_pkg::GID_EXT |=>
		rsp_gid_r == nfcic_pkg::GID_EXT && rsp_plen_r == nfcic_pkg::PLEN_EXT)
		else $error("activation answer malformed");
	a_prop_gate: assert property ($rose(pntf_r) |-> $past(ext_en_r))
		else $error("proprietary notice without activation");
	// the reset answer may only rise once nothing was left unread
	a_reset_hold: assert property ($rose(rsp_v_r) && rsp_gid_r == nfcic_pkg::GID_CORE &&
		rsp_oid_r == nfcic_pkg::OID_RESET |-> !$past(pend))
		else $error("reset answered over pending data");
	a_mfr_bytes: assert property (rst_exec |=> ntf_v_r && rsp_v_r &&
		rsp_oid_r == nfcic_pkg::OID_RESET)
		else $error("reset notice missing");
	a_ready_pair: assert property ($rose(seq_r == nfcic_pkg::SQ_READY) |->
		$past(seq_r) == nfcic_pkg::SQ_RST) else $error("ready without reset pair");
	a_clock_request_pin_need: assert property (!need ##1 !need |-> !clk_req_r)
		else $error("clock requested without need");
	a_settle_wait: assert property ($rose(clk_ok_r) |-> $past(clk_req_r, 2))
		else $error("clock stable too early");
	a_cfg_wipe: assert property (rst_exec && !rst_keep_r |=>
		ncicfg_r == 32'h0 && !mapped_r && !routed_r)
		else $error("configuration kept after wipe");

	c_ext_ok: cover property (ext_en_r && pntf_r);
	c_rst_held: cover property (rst_wait_r && pend ##[1:20] rst_exec);
	c_clk_ok: cover property ($rose(clk_ok_r));
endmodule : nfcic_top

`default_nettype wire

/* File: logic/nfcic_pkg.sv */
// shared constants for the nfc init and clock request block
package nfcic_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CMD     = 8'h00;
	localparam logic [7:0] OFS_RSP     = 8'h04;
	localparam logic [7:0] OFS_RSPSTAT = 8'h08;
	localparam logic [7:0] OFS_BUILD   = 8'h0c;
	localparam logic [7:0] OFS_MFR     = 8'h10;
	localparam logic [7:0] OFS_STATUS  = 8'h14;
	localparam logic [7:0] OFS_CLKCFG  = 8'h18;
	localparam logic [7:0] OFS_CTRL    = 8'h1c;
	localparam logic [7:0] OFS_NCICFG  = 8'h20;
	// command and response word layout
	localparam int HDR_GID  = 0;
	localparam int HDR_OID  = 4;
	localparam int HDR_PLEN = 16;
	localparam int CMD_KEEP = 24;
	localparam int RSP_VLD  = 31;
	// group and opcode codes
	localparam logic [3:0] GID_CORE = 4'h0;
	localparam logic [3:0] GID_RF   = 4'h1;
	localparam logic [3:0] GID_EXT  = 4'hf;
	localparam logic [5:0] OID_RESET    = 6'h00;
	localparam logic [5:0] OID_INIT     = 6'h01;
	localparam logic [5:0] OID_SETCFG   = 6'h02;
	localparam logic [5:0] OID_EXT_ACT  = 6'h02;
	localparam logic [5:0] OID_MAP      = 6'h00;
	localparam logic [5:0] OID_ROUTING  = 6'h01;
	localparam logic [5:0] OID_DISCOVER = 6'h03;
	// status codes and response lengths
	localparam logic [7:0] STAT_OK     = 8'h00;
	localparam logic [7:0] STAT_FAILED = 8'h03;
	localparam logic [7:0] PLEN_EXT    = 8'h05;
	localparam logic [7:0] PLEN_STAT   = 8'h01;
	// clock config fields and reset value
	localparam int CLK_PLL  = 0;
	localparam int CLK_FREQ = 1;
	localparam int CLK_TMO  = 16;
	localparam logic [31:0] CLKCFG_RST = 32'h000a_0000;
	localparam int CTRL_FWDL = 0;
	// status register bits
	localparam int ST_READY = 0;
	localparam int ST_EXT   = 1;
	localparam int ST_CLKRQ = 2;
	localparam int ST_CLKOK = 3;
	localparam int ST_RWAIT = 4;
	localparam int ST_PNTF  = 5;
	localparam int ST_DISC  = 6;
	localparam int ST_RSPV  = 7;
	localparam int ST_NTFV  = 8;
	// settle timeout unit
	localparam int CLK_PERIOD_NS = 20;
	localparam int TICK_NS       = 1000;
	localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// reset and init sequence state
	typedef enum logic [2:0] {
		SQ_IDLE  = 3'b001,
		SQ_RST   = 3'b010,
		SQ_READY = 3'b100
	} nfcic_seq_t;
endpackage : nfcic_pkg

/* File: testbench/nfcic_host_model.sv */
// host model: axi4-lite master that hands nci commands to the device
`timescale 1ns/1ns
`default_nettype none
module nfcic_host_model (
	// clock
	input  wire logic       aclk,
	// write channels
	output logic [7:0]      s_awaddr,
	output logic            s_awvalid,
	input  wire logic       s_awready,
	output logic [31:0]     s_wdata,
	output logic [3:0]      s_wstrb,
	output logic            s_wvalid,
	input  wire logic       s_wready,
	input  wire logic [1:0] s_bresp,
	input  wire logic       s_bvalid,
	output logic            s_bready,
	// read channels
	output logic [7:0]      s_araddr,
	output logic            s_arvalid,
	input  wire logic       s_arready,
	input  wire logic       s_rvalid,
	output logic            s_rready
);
	// idle bus at time zero
	initial begin
		{s_awaddr, s_awvalid, s_wdata, s_wstrb, s_wvalid, s_bready} = '0;
		{s_araddr, s_arvalid, s_rready} = '0;
	end
	// one write; a released payload shows its inverse, never the stale value
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		logic aw_left;
		logic w_left;
		aw_left = 1'b1;
		w_left = 1'b1;
		s_awaddr <= a;
		s_wdata <= d;
		s_wstrb <= 4'hf;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		while (aw_left || w_left) begin
			@(posedge aclk);
			if (aw_left && s_awready) begin
				aw_left = 1'b0;
				s_awvalid <= 1'b0;
				s_awaddr <= ~a;
			end
			if (w_left && s_wready) begin
				w_left = 1'b0;
				s_wvalid <= 1'b0;
				s_wdata <= ~d;
			end
		end
		s_bready <= 1'b1;
		do @(posedge aclk); while (s_bvalid !== 1'b1);
		resp = s_bresp;
		s_bready <= 1'b0;
	endtask : wr
	// one read; data is picked up by the bench monitor at the rvalid edge
	task automatic rd(input logic [7:0] a);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		do @(posedge aclk); while (s_arready !== 1'b1);
		s_arvalid <= 1'b0;
		s_araddr <= ~a;
		s_rready <= 1'b1;
		do @(posedge aclk); while (s_rvalid !== 1'b1);
		s_rready <= 1'b0;
	endtask : rd
	// command word: group, opcode, no parameters, keep flag
	function automatic logic [31:0] cmd_word(input logic [3:0] g, input logic [5:0] o,
		input logic keep);
		return {7'h00, keep, 8'h00, 6'h00, o, g};
	endfunction : cmd_word
endmodule : nfcic_host_model
`default_nettype wire

/* File: testbench/test_nfc_init_and_clock_request.sv */
// self-checking bench for the nfc init and clock request block
`timescale 1ns/1ns
`default_nettype none
module test_nfc_init_and_clock_request;
	typedef struct packed {logic [31:0] m; logic [1:0] r; logic [31:0] d;} nfcic_exp_t;
	logic        aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic        s_arvalid, s_arready, s_rvalid, s_rready, prop_event;
	logic        data_pending, clock_request_pin, clock_stable, carrier_on;
	logic [7:0]  s_awaddr, s_araddr;
	logic [31:0] s_wdata, s_rdata, v;
	logic [3:0]  s_wstrb;
	logic [1:0]  s_bresp, s_rresp;
	int          num_errors, checks, seed, n;
	nfcic_exp_t  exp_q[$];
	nfcic_top i_nfcic_top (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
		.s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
		.s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .prop_event,
		.data_pending, .clock_request_pin, .clock_stable, .carrier_on);
	nfcic_host_model i_nfcic_host_model (.aclk, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
		.s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
		.s_arvalid, .s_arready, .s_rvalid, .s_rready);
	// 50 mhz clock
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : finish_test
	// read monitor: oldest note against each read answer
	always @(posedge aclk) begin
		if (s_rvalid === 1'b1 && s_rready === 1'b1) begin
			chk({30'h0, s_rresp}, {30'h0, exp_q[0].r});
			chk(s_rdata & exp_q[0].m, exp_q[0].d);
			void'(exp_q.pop_front());
		end
	end
	// bus helpers: a read notes its expectation first, a write checks its answer after the host model runs the cycle
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = '1,
		input logic [1:0] r = nfcic_pkg::RESP_OKAY);
		exp_q.push_back('{m: m, r: r, d: d});
		i_nfcic_host_model.rd(a);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = nfcic_pkg::RESP_OKAY);
		logic [1:0] got;
		i_nfcic_host_model.wr(a, d, got);
		chk({30'h0, got}, {30'h0, r});
	endtask : wr
	// command with its status and response header; plen masked except when given
	task automatic cmd(input logic [3:0] g, input logic [5:0] o, input logic k,
		input logic [7:0] st, input logic [31:0] m = 32'h8000_03ff);
		wr(nfcic_pkg::OFS_CMD, i_nfcic_host_model.cmd_word(g, o, k));
		rd(nfcic_pkg::OFS_RSPSTAT, {24'h0, st}, 32'h0000_00ff);
		rd(nfcic_pkg::OFS_RSP, {8'h80, nfcic_pkg::PLEN_EXT, 6'h0, o, g} & m, m);
	endtask : cmd
	// reset then init back to back, notice read in between
	task automatic rst_init(input logic k);
		cmd(nfcic_pkg::GID_CORE, nfcic_pkg::OID_RESET, k, nfcic_pkg::STAT_OK);
		rd(nfcic_pkg::OFS_MFR, 32'h0001_2211);
		cmd(nfcic_pkg::GID_CORE, nfcic_pkg::OID_INIT, 1'b0, nfcic_pkg::STAT_OK);
	endtask : rst_init
	task automatic pin_chk(input logic req, input logic car);
		repeat (3) @(posedge aclk);
		chk({31'h0, clock_request_pin}, {31'h0, req});
		chk({31'h0, carrier_on}, {31'h0, car});
	endtask : pin_chk
	// watchdog
	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		finish_test();
	end
	// main sequence
	initial begin
		{aresetn, prop_event, num_errors, checks, n} = '0;
		seed = 84428;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(nfcic_pkg::OFS_CLKCFG, nfcic_pkg::CLKCFG_RST);
		rd(nfcic_pkg::OFS_CTRL, 32'h0);
		rd(8'h40, 32'h0, '1, nfcic_pkg::RESP_SLVERR);
		wr(nfcic_pkg::OFS_MFR, 32'h1, nfcic_pkg::RESP_SLVERR);
		cmd(nfcic_pkg::GID_CORE, nfcic_pkg::OID_INIT, 1'b0, nfcic_pkg::STAT_FAILED);
		cmd(nfcic_pkg::GID_EXT, nfcic_pkg::OID_EXT_ACT, 1'b0, nfcic_pkg::STAT_FAILED);
		$display("test reset_values done");
		rst_init(1'b0);
		rd(nfcic_pkg::OFS_STATUS, 32'h1, 32'h1);
		prop_event <= 1'b1;
		@(posedge aclk);
		prop_event <= 1'b0;
		rd(nfcic_pkg::OFS_STATUS, 32'h0, 32'h20);
		cmd(nfcic_pkg::GID_EXT, nfcic_pkg::OID_EXT_ACT, 1'b0, nfcic_pkg::STAT_OK, '1);
		rd(nfcic_pkg::OFS_BUILD, 32'h0000_0001);
		prop_event <= 1'b1;
		@(posedge aclk);
		prop_event <= 1'b0;
		repeat (2) @(posedge aclk);
		chk({31'h0, data_pending}, 32'h1);
		rd(nfcic_pkg::OFS_STATUS, 32'h22, 32'h22);
		$display("test activation done");
		v = $random(seed);
		wr(nfcic_pkg::OFS_NCICFG, v);
		rst_init(1'b1);
		rd(nfcic_pkg::OFS_NCICFG, v);
		rst_init(1'b0);
		rd(nfcic_pkg::OFS_NCICFG, 32'h0);
		rd(nfcic_pkg::OFS_STATUS, 32'h0, 32'h2);
		$display("test reset_types done");
		wr(nfcic_pkg::OFS_CMD, i_nfcic_host_model.cmd_word(4'h0, 6'h02, 1'b0));
		wr(nfcic_pkg::OFS_CMD, i_nfcic_host_model.cmd_word(4'h0, 6'h00, 1'b1));
		chk({31'h0, data_pending}, 32'h1);
		rd(nfcic_pkg::OFS_STATUS, 32'h90, 32'h90);
		rd(nfcic_pkg::OFS_RSP, 32'h8000_0020, 32'h8000_03ff);
		rd(nfcic_pkg::OFS_RSP, 32'h8000_0000, 32'h8000_03ff);
		rd(nfcic_pkg::OFS_MFR, 32'h0001_2211);
		cmd(nfcic_pkg::GID_CORE, nfcic_pkg::OID_INIT, 1'b0, nfcic_pkg::STAT_OK);
		$display("test held_reset done");
		// crystal mode, random frequency code among the seven pll inputs
		v = {$random(seed)} % 7;
		wr(nfcic_pkg::OFS_CLKCFG, {16'h0002, 12'h0, v[2:0], 1'b0});
		cmd(4'h1, 6'h00, 1'b0, nfcic_pkg::STAT_OK);
		cmd(4'h0, 6'h02, 1'b0, nfcic_pkg::STAT_OK);
		cmd(4'h1, 6'h01, 1'b0, nfcic_pkg::STAT_OK);
		cmd(4'h1, 6'h03, 1'b0, nfcic_pkg::STAT_OK);
		pin_chk(1'b0, 1'b1);
		wr(nfcic_pkg::OFS_CLKCFG, {16'h0002, 12'h0, v[2:0], 1'b1});
		while (clock_request_pin !== 1'b1 && n < 10) begin
			@(posedge aclk);
		end
		while (clock_stable !== 1'b1 && n < 300) begin
			@(posedge aclk);
			n++;
		end
		chk({31'h0, (n >= 96 && n <= 106)}, 32'h1);
		// full wipe with map and routing set; clock words must survive it
		rst_init(1'b0);
		pin_chk(1'b0, 1'b0);
		chk({31'h0, clock_stable}, 32'h0);
		wr(nfcic_pkg::OFS_CTRL, 32'h1);
		pin_chk(1'b1, 1'b0);
		wr(nfcic_pkg::OFS_CTRL, 32'h0);
		pin_chk(1'b0, 1'b0);
		$display("test clock_request done");
		finish_test();
	end
endmodule : test_nfc_init_and_clock_request
`default_nettype wire
